// ---- rtl/emwss_consts.vh ----
// constants for the external memory write strobe and space select block
// assumes a 10 MHz core clock; included by bare name
`ifndef EMWSS_CONSTS_VH
`define EMWSS_CONSTS_VH
`define EMWSS_DATA_W        16
`define EMWSS_ADDR_W        24
`define EMWSS_PORTD_BIT_PS  4'h8
`define EMWSS_PORTD_BIT_DS  4'h9
`define EMWSS_ST_IDLE       3'h0
`define EMWSS_ST_SETUP      3'h1
`define EMWSS_ST_WSTRB      3'h2
`define EMWSS_ST_RSTRB      3'h3
`define EMWSS_ST_HOLD       3'h4
`define EMWSS_SPACE_PROG    1'b0
`define EMWSS_SPACE_DATA    1'b1
`define EMWSS_STROBE_CYC    2'h2
`endif

// ---- rtl/emwss_ctrl.v ----
// write strobe, read strobe and program/data space selects of the external memory port
// assumes a single-cycle request from core logic on core_clk; pins resolved outside
//
// Operation
// RQ1: write strobe low throughout each external write cycle, high otherwise.
// RQ2: while write strobe low, data pins are outputs carrying write data.
// RQ3: external memory captures data on write strobe rising edge.
// RQ4: asserted strobe qualifies address, program/data selects and chip selects.
// RQ5: idle bus: strobe and selects tri-stated or driven per keep-driven bit.
// RQ6: program select is chip select zero, set at reset, low for program access.
// RQ7: data select is chip select one, set at reset, low for data access.
// RQ8: write strobe pull-up enabled unless control pull-up-disable bit set.
// RQ9: program select pin doubles as port D bit eight; its pull-up bit disables.
// RQ10: data select pin doubles as port D bit nine; its pull-up bit disables.
// RQ11: read strobe low on reads, data pins inputs, data latched on rising edge; code keeps the data sampled one cycle before the read strobe rises.
// RQ12: select asserted no later than strobe; address and data held until it rises.
// RQ13: during reset strobes and selects disabled, pins pulled high.
`timescale 1ns/1ps
`default_nettype none
`include "emwss_consts.vh"
module emwss_ctrl (
  // clock and reset
  input  wire                       core_clk,
  input  wire                       rst,
  // core request
  input  wire                       req_valid,
  input  wire                       req_write,
  input  wire                       req_space,
  input  wire [`EMWSS_ADDR_W-1:0]   req_addr,
  input  wire [`EMWSS_DATA_W-1:0]   req_wdata,
  output reg                        req_busy,
  output reg                        rd_done,
  output reg  [`EMWSS_DATA_W-1:0]   rd_data,
  // configuration bits
  input  wire                       idle_bus_keep_driven,
  input  wire                       ctrl_pullup_disable,
  input  wire [15:0]                port_d_pullup_enable_reg,
  input  wire                       port_d_bit_eight_gpio,
  input  wire                       port_d_bit_nine_gpio,
  input  wire                       port_d_bit_eight_out,
  input  wire                       port_d_bit_eight_oe,
  input  wire                       port_d_bit_nine_out,
  input  wire                       port_d_bit_nine_oe,
  // memory pins
  output reg  [`EMWSS_ADDR_W-1:0]   addr_out,
  output reg                        write_strobe_n_o,
  output reg                        write_strobe_n_oe,
  output reg                        write_strobe_pu,
  output reg                        read_strobe_n_o,
  output reg                        read_strobe_n_oe,
  output reg                        chip_select_zero_n_o,
  output reg                        chip_select_zero_n_oe,
  output reg                        chip_select_zero_pu,
  output reg                        chip_select_one_n_o,
  output reg                        chip_select_one_n_oe,
  output reg                        chip_select_one_pu,
  output reg  [`EMWSS_DATA_W-1:0]   data_o,
  output reg                        data_oe,
  input  wire [`EMWSS_DATA_W-1:0]   data_i
);

  reg [2:0]                 state;
  reg                       cur_write;
  reg                       cur_space;
  reg [1:0]                 cnt;
  reg [`EMWSS_DATA_W-1:0]   data_s1;
  reg [`EMWSS_DATA_W-1:0]   data_s2;
  reg                       cs0_role_ps;
  reg                       cs1_role_ds;
  reg                       active;

  // select decode: fresh request in idle, or transfer running before hold
  function emwss_sel_hit;
    input [2:0] st;
    input       valid;
    input       role;
    input       want;
    input       space_new;
    input       space_cur;
    reg         take_hit;
    reg         run_hit;
    begin
      take_hit      = (st == `EMWSS_ST_IDLE) && valid && (space_new == want);
      run_hit       = (st != `EMWSS_ST_IDLE) && (st != `EMWSS_ST_HOLD) && (space_cur == want);
      emwss_sel_hit = role && (take_hit || run_hit);
    end
  endfunction

  // strobe low from setup of matching direction until last strobe cycle
  function emwss_strobe_on;
    input [2:0] st;
    input [2:0] strobe_st;
    input       dir_match;
    input [1:0] count;
    begin
      emwss_strobe_on = ((st == `EMWSS_ST_SETUP) && dir_match)
                        || ((st == strobe_st) && (count != 2'h1));
    end
  endfunction

  // pins driven on any active cycle, or always when keep-driven set
  function emwss_bus_drive;
    input keep;
    input busy_state;
    input valid;
    begin
      emwss_bus_drive = keep | busy_state | valid;
    end
  endfunction

  // bus pins sampled through two flops
  always @(posedge core_clk) begin
    data_s1 <= data_i;
    data_s2 <= data_s1;
  end

  always @* begin
    active = (state != `EMWSS_ST_IDLE);
  end

  always @(posedge core_clk) begin
    if (rst) begin
      state                 <= `EMWSS_ST_IDLE;
      cur_write             <= 1'b0;
      cur_space             <= 1'b0;
      cnt                   <= 2'h0;
      req_busy              <= 1'b0;
      rd_done               <= 1'b0;
      rd_data               <= {`EMWSS_DATA_W{1'b0}};
      cs0_role_ps           <= 1'b1;                 // [RQ6]
      cs1_role_ds           <= 1'b1;                 // [RQ7]
      addr_out              <= {`EMWSS_ADDR_W{1'b0}};
      write_strobe_n_o      <= 1'b1;
      write_strobe_n_oe     <= 1'b0;                 // [RQ13]
      write_strobe_pu       <= 1'b1;                 // [RQ13]
      read_strobe_n_o       <= 1'b1;
      read_strobe_n_oe      <= 1'b0;
      chip_select_zero_n_o  <= 1'b1;
      chip_select_zero_n_oe <= 1'b0;                 // [RQ13]
      chip_select_zero_pu   <= 1'b1;
      chip_select_one_n_o   <= 1'b1;
      chip_select_one_n_oe  <= 1'b0;                 // [RQ13]
      chip_select_one_pu    <= 1'b1;
      data_o                <= {`EMWSS_DATA_W{1'b0}};
      data_oe               <= 1'b0;
    end else begin
      rd_done <= 1'b0;
      case (state)
        `EMWSS_ST_IDLE: begin
          if (req_valid) begin
            cur_write <= req_write;
            cur_space <= req_space;
            addr_out  <= req_addr;                   // [RQ12]
            data_o    <= req_wdata;
            req_busy  <= 1'b1;
            state     <= `EMWSS_ST_SETUP;
          end
        end
        `EMWSS_ST_SETUP: begin
          cnt   <= `EMWSS_STROBE_CYC;
          state <= cur_write ? `EMWSS_ST_WSTRB : `EMWSS_ST_RSTRB;
        end
        `EMWSS_ST_WSTRB: begin
          cnt <= cnt - 2'h1;
          if (cnt == 2'h1)
            state <= `EMWSS_ST_HOLD;
        end
        `EMWSS_ST_RSTRB: begin
          cnt <= cnt - 2'h1;
          if (cnt == 2'h1)
            state <= `EMWSS_ST_HOLD;
        end
        `EMWSS_ST_HOLD: begin
          // synchroniser lags two cycles, so strobed data arrives here
          if (!cur_write) begin
            rd_data <= data_s2;                      // [RQ11]
            rd_done <= 1'b1;
          end
          req_busy <= 1'b0;
          state    <= `EMWSS_ST_IDLE;
        end
        default: state <= `EMWSS_ST_IDLE;
      endcase

      // pin drive, registered from current state, so pins lag the state by one cycle
      write_strobe_n_o  <= ~emwss_strobe_on(state, `EMWSS_ST_WSTRB, cur_write, cnt);  // [RQ1]
      read_strobe_n_o   <= ~emwss_strobe_on(state, `EMWSS_ST_RSTRB, !cur_write, cnt); // [RQ11]
      // data held driven one cycle past strobe rise
      data_oe           <= (state == `EMWSS_ST_SETUP && cur_write)
                           || (state == `EMWSS_ST_WSTRB && cnt != 2'h1)
                           || (state == `EMWSS_ST_WSTRB && cnt == 2'h1); // [RQ2] [RQ12]
      // space selects, low from take until hold
      chip_select_zero_n_o <= ~emwss_sel_hit(state,
                                             req_valid,
                                             cs0_role_ps,
                                             `EMWSS_SPACE_PROG,
                                             req_space,
                                             cur_space);           // [RQ6] [RQ4] [RQ12]
      chip_select_one_n_o  <= ~emwss_sel_hit(state,
                                             req_valid,
                                             cs1_role_ds,
                                             `EMWSS_SPACE_DATA,
                                             req_space,
                                             cur_space);           // [RQ7] [RQ4] [RQ12]
      // output enables
      write_strobe_n_oe     <= emwss_bus_drive(idle_bus_keep_driven, active, req_valid);  // [RQ5]
      read_strobe_n_oe      <= emwss_bus_drive(idle_bus_keep_driven, active, req_valid);
      chip_select_zero_n_oe <= port_d_bit_eight_gpio ? port_d_bit_eight_oe
                               : emwss_bus_drive(idle_bus_keep_driven, active, req_valid); // [RQ5] [RQ9]
      chip_select_one_n_oe  <= port_d_bit_nine_gpio ? port_d_bit_nine_oe
                               : emwss_bus_drive(idle_bus_keep_driven, active, req_valid); // [RQ5] [RQ10]
      // port d fallback overrides select drive
      if (port_d_bit_eight_gpio)
        chip_select_zero_n_o <= port_d_bit_eight_out; // [RQ9]
      if (port_d_bit_nine_gpio)
        chip_select_one_n_o <= port_d_bit_nine_out;  // [RQ10]
      // pull-ups
      write_strobe_pu     <= ~ctrl_pullup_disable;   // [RQ8]
      chip_select_zero_pu <= port_d_pullup_enable_reg[`EMWSS_PORTD_BIT_PS]; // [RQ9]
      chip_select_one_pu  <= port_d_pullup_enable_reg[`EMWSS_PORTD_BIT_DS]; // [RQ10]
    end
  end

endmodule // emwss_ctrl
`default_nettype wire

// ---- testbench/emwss_ctrl_chk.sv ----
// pin timing checker for emwss_ctrl
// sees only the top module's ports
`timescale 1ns/1ps
`default_nettype none
module emwss_ctrl_chk (
  input wire logic core_clk, rst, req_valid, req_space, req_busy, rd_done, idle_bus_keep_driven,
  input wire logic [23:0] addr_out,
  input wire logic [15:0] data_o,
  input wire logic data_oe, write_strobe_n_o, write_strobe_n_oe, write_strobe_pu, read_strobe_n_o,
  input wire logic chip_select_zero_n_o, chip_select_zero_n_oe, chip_select_one_n_o, chip_select_one_n_oe);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence wr_low2; !write_strobe_n_o [*2] ##1 write_strobe_n_o; endsequence
  sequence take(s); req_valid && !req_busy && req_space == s; endsequence
  AST_WR_WIDTH: assert property ($fell(write_strobe_n_o) |-> wr_low2) else $error("strobe width");
  AST_WR_DATA: assert property (!write_strobe_n_o |-> data_oe && write_strobe_n_oe) else $error("bus");
  AST_WR_QUAL: assert property (!write_strobe_n_o |-> chip_select_zero_n_o != chip_select_one_n_o)
    else $error("no select");
  AST_IDLE: assert property (!req_busy [*3] ##0 $stable(idle_bus_keep_driven)
    |-> write_strobe_n_oe == idle_bus_keep_driven) else $error("idle drive");
  AST_PROG_SEL: assert property (take(1'b0) |=> !chip_select_zero_n_o && chip_select_one_n_o)
    else $error("program select");
  AST_DATA_SEL: assert property (take(1'b1) |=> !chip_select_one_n_o && chip_select_zero_n_o)
    else $error("data select");
  AST_HOLD: assert property (!write_strobe_n_o |-> $stable(addr_out) && $stable(data_o)) else $error("moved");
  AST_RD: assert property ($fell(read_strobe_n_o) |-> !data_oe ##3 rd_done) else $error("read");
  AST_RESET: assert property (disable iff (1'b0) rst |=> write_strobe_pu && !write_strobe_n_oe
    && !chip_select_zero_n_oe && !chip_select_one_n_oe) else $error("reset state");
endmodule // emwss_ctrl_chk
bind emwss_ctrl emwss_ctrl_chk chk (.*);
`default_nettype wire

// ---- testbench/emwss_mem_model.sv ----
// static memory on the far side of emwss_ctrl
// pins arrive resolved; undriven strobes and selects read high
`timescale 1ns/1ps
`default_nettype none
module emwss_mem_model (
  input wire logic core_clk, wr_n, rd_n, cs0_n, cs1_n, dq_oe,
  input wire logic [23:0] addr,
  input wire logic [15:0] dq_out,
  output logic [15:0] dq);
  logic [15:0] mem [0:31];
  logic [15:0] last = 16'h0000, wd;
  logic [4:0] wi;
  wire [4:0] idx = {cs0_n, addr[3:0]};
  wire sel = !(cs0_n && cs1_n);
  always @(negedge core_clk) begin
    last <= dq;
    if (!wr_n && sel) begin
      wi <= idx;
      wd <= dq_out;
    end
  end
  always @(posedge wr_n) mem[wi] <= wd;
  always @* dq = dq_oe ? dq_out : (!rd_n && sel) ? mem[idx] : ~last;
endmodule // emwss_mem_model
`default_nettype wire

// ---- testbench/tb_emwss_ctrl.sv ----
// self-checking bench for emwss_ctrl
// 10 MHz clock; inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_emwss_ctrl;
  logic core_clk = 0, rst = 1, req_valid = 0, req_write = 0, req_space = 0, idle_bus_keep_driven = 0;
  logic ctrl_pullup_disable = 0, port_d_bit_eight_gpio = 0, port_d_bit_nine_gpio = 0;
  logic port_d_bit_eight_out = 0, port_d_bit_eight_oe = 0, port_d_bit_nine_out = 0, port_d_bit_nine_oe = 0;
  logic [23:0] req_addr = 0, addr_out;
  logic [15:0] req_wdata = 0, port_d_pullup_enable_reg = 16'hFFFF, rd_data, data_o, data_i;
  logic req_busy, rd_done, write_strobe_n_o, write_strobe_n_oe, write_strobe_pu, read_strobe_n_o;
  logic read_strobe_n_oe, chip_select_zero_n_o, chip_select_zero_n_oe, chip_select_zero_pu;
  logic chip_select_one_n_o, chip_select_one_n_oe, chip_select_one_pu, data_oe;
  int num_errors = 0, checks = 0;
  logic [41:0] rows [4] = '{{2'h2, 24'h3, 16'hA55A}, {2'h3, 24'h3, 16'h1234},
                            {2'h0, 24'h3, 16'hA55A}, {2'h1, 24'h3, 16'h1234}};
  emwss_ctrl uut (.*);
  emwss_mem_model ram (.core_clk(core_clk), .addr(addr_out), .dq_out(data_o), .dq_oe(data_oe), .dq(data_i),
    .wr_n(write_strobe_n_o | !write_strobe_n_oe), .rd_n(read_strobe_n_o | !read_strobe_n_oe),
    .cs0_n(chip_select_zero_n_o | !chip_select_zero_n_oe), .cs1_n(chip_select_one_n_o | !chip_select_one_n_oe));
  task automatic chk(input string nm, input logic [23:0] e, g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic [41:0] r);
    {req_write, req_space, req_addr, req_wdata} = r;
    req_valid = 1;
    @(posedge core_clk) #1 req_valid = 0;
    repeat (6) @(posedge core_clk);
    #1 if (r[41]) chk("mem", r[15:0], ram.mem[{r[40], r[19:16]}]);
    else chk("rd_data", r[15:0], rd_data);
  endtask
  task automatic end_of_test;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always #50 core_clk = ~core_clk;
  initial begin
    #20000 num_errors++;
    end_of_test;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    #1 chk("oe", 0, {write_strobe_n_oe, chip_select_zero_n_oe, chip_select_one_n_oe});
    chk("pu", 24'h7, {write_strobe_pu, chip_select_zero_pu, chip_select_one_pu});
    rst = 0;
    foreach (rows[i]) xfer(rows[i]);
    ctrl_pullup_disable = 1;
    port_d_pullup_enable_reg = 16'h0100;
    idle_bus_keep_driven = 1;
    {port_d_bit_eight_gpio, port_d_bit_eight_oe} = 2'h3;
    repeat (3) @(posedge core_clk);
    #1 chk("pu cfg", 24'h2, {write_strobe_pu, chip_select_zero_pu, chip_select_one_pu});
    chk("idle oe", 24'h7, {write_strobe_n_oe, chip_select_zero_n_oe, chip_select_one_n_oe});
    chk("gpio", 0, chip_select_zero_n_o);
    port_d_bit_eight_gpio = 0;
    xfer({2'h3, 24'hFFFFFF, 16'hFFFF});
    xfer({2'h1, 24'hFFFFFF, 16'hFFFF});
    end_of_test;
  end
endmodule // tb_emwss_ctrl
`default_nettype wire
